// file: logic/adc_ctrl_defines.svh
// register offsets, field positions, reset values and timing counts of the converter control
`ifndef ADC_CTRL_DEFINES_SVH
`define ADC_CTRL_DEFINES_SVH

`define ADDR_MODE        8'h00
`define ADDR_CONFIG      8'h04
`define ADDR_STATUS      8'h08
`define ADDR_DATA        8'h0C
`define ADDR_OFFSET_COEF 8'h10
`define ADDR_FSCALE_COEF 8'h14

`define MODE_OP_LSB      0
`define CFG_CH_LSB       0
`define CFG_REFERENCE_SELECT_BIT   3
`define CFG_GAIN_LSB     8
`define STAT_READY_BIT   0
`define STAT_CAL_BIT     1
`define STAT_RSTWAIT_BIT 2
`define STAT_REFINT_BIT  3
`define STAT_CH_LSB      4

`define OP_CONTINUOUS    3'h0
`define OP_SINGLE        3'h1
`define OP_IDLE          3'h2
`define OP_POWER_DOWN    3'h3
`define OP_INT_ZERO      3'h4
`define OP_INT_FULL      3'h5
`define OP_SYS_ZERO      3'h6
`define OP_SYS_FULL      3'h7

`define MODE_RESET       3'h0
`define CH_RESET         3'h0
`define GAIN_RESET       3'h0
`define REFERENCE_SELECT_RESET     1'b0
`define OFFSET_RESET     24'h00_0000
`define FSCALE_RESET     24'h80_0000

`define SUPPLY_CHANNEL   3'h7
`define GAIN_ONE         3'h0
`define RESET_ONES       6'd32
`define CAL_CONV_SHORT   3'd2
`define CAL_CONV_LONG    3'd4
`define RESET_WAIT_NS    500000
`define CLK_PERIOD_NS    50

`endif

// file: logic/adc_ctrl_pkg.sv
// types shared by the converter control modules
package adc_ctrl_pkg;
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_CONVERT,
        ST_CALIBRATE,
        ST_POWER_DOWN
    } ctrl_state_t;

    typedef enum logic [1:0] {
        SEL_CHANNEL,
        SEL_ZERO,
        SEL_FULL,
        SEL_SUPPLY
    } input_sel_t;
endpackage : adc_ctrl_pkg

// file: logic/coef_scaler.sv
// offset subtraction and full-scale multiplication of a raw conversion result
`timescale 1ns/1ps
module coef_scaler #(
    parameter int unsigned W = 24
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic         valid_i,
    input  wire logic [W-1:0] raw_i,
    input  wire logic [W-1:0] offset_i,
    input  wire logic [W-1:0] scale_i,
    output logic      [W-1:0] result_o,
    output logic              valid_o
);
    logic signed [W:0]     diff;
    logic [W-1:0]          mag;
    logic [2*W-1:0]        prod;

    // scale is fixed point with W-1 fraction bits; below zero clamps low, overflow clamps high
    always_comb begin
        diff = $signed({1'b0, raw_i}) - $signed({1'b0, offset_i});
        mag  = diff[W] ? '0 : diff[W-1:0];
        prod = mag * scale_i;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            result_o <= '0;
            valid_o  <= 1'b0;
        end else begin
            valid_o <= valid_i;
            if (valid_i) begin
                result_o <= prod[2*W-1] ? '1 : prod[2*W-2:W-1];
            end
        end
    end
endmodule : coef_scaler

// file: logic/adc_ctrl.sv
// reset, reference, supply monitor and calibration control of the converter
//
// Overview of operation
// - thirty-two consecutive ones on the serial input reset the device and interface
// - reset restarts control logic and modulator and restores every register
// - the same reset happens by itself at power-up
// - channel code all ones converts supply divided by six on internal reference
// - reference select picks internal or external; internal never reaches the pins
// - four mode codes start zero or full-scale calibration, internal or system
// - each result has offset subtracted then is multiplied by full-scale coefficient
// - calibration end updates coefficient, sets ready, drops ready pin, goes idle
// - internal calibrations switch the zero or full-scale source onto the input
// - offset calibrations, internal or system, take two conversion cycles
// - internal full-scale takes two conversions at gain one, four otherwise
// - the full-scale coefficient goes to the selected channel's register
// - system full-scale takes two conversions at any gain and any rate
`timescale 1ns/1ps
`include "adc_ctrl_defines.svh"
module adc_ctrl #(
    parameter int unsigned RESULT_W          = 24,
    parameter int unsigned RESET_WAIT_CYCLES =
        (`RESET_WAIT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
    input  wire logic                clk_i,
    input  wire logic                rst_i,
    input  wire logic [7:0]          wb_adr_i,
    input  wire logic [31:0]         wb_dat_i,
    input  wire logic [3:0]          wb_sel_i,
    input  wire logic                wb_we_i,
    input  wire logic                wb_cyc_i,
    input  wire logic                wb_stb_i,
    output logic      [31:0]         wb_dat_o,
    output logic                     wb_ack_o,
    input  wire logic                sclk_i,
    input  wire logic                din_i,
    input  wire logic                cs_n_i,
    output logic                     dout_rdy_o,
    output logic                     dout_rdy_oe_n_o,
    input  wire logic [RESULT_W-1:0] raw_data_i,
    input  wire logic                raw_valid_i,
    output logic      [1:0]          input_sel_o,
    output logic      [2:0]          channel_o,
    output logic      [2:0]          gain_code_o,
    output logic                     ref_internal_o,
    output logic                     ext_ref_connect_o,
    output logic                     modulator_reset_o,
    output logic                     conv_restart_o,
    output logic                     power_down_o
);
    localparam int unsigned RW_W = $clog2(RESET_WAIT_CYCLES + 1);

    logic [2:0]                  sync1_q;
    logic [2:0]                  sync2_q;
    logic                        sclk_prev_q;
    logic [5:0]                  ones_cnt_q;
    logic                        serial_reset_q;
    logic                        reset_any;
    logic [RW_W-1:0]             rst_wait_q;

    logic                        ack_q;
    logic [31:0]                 rdata_q;
    logic                        req;
    logic                        wr_en;
    logic                        rd_data_en;
    logic [31:0]                 wmerged;
    logic [31:0]                 status_word;

    adc_ctrl_pkg::ctrl_state_t   state_q;
    logic [2:0]                  mode_q;
    logic [2:0]                  channel_q;
    logic [2:0]                  gain_q;
    logic                        reference_select_q;
    logic [2:0]                  cal_cnt_q;
    logic [2:0]                  cal_need_q;
    logic                        mode_write;
    logic [2:0]                  new_mode;
    logic                        cal_start;
    logic                        cal_done;
    logic [1:0]                  coef_idx;

    logic [RESULT_W-1:0]         offset_q [4];
    logic [RESULT_W-1:0]         fscale_q [4];
    logic [RESULT_W-1:0]         data_q;
    logic [RESULT_W-1:0]         scaled;
    logic                        scaled_valid;
    logic                        result_load;
    logic                        ready_q;
    logic                        rdy_n_q;
    adc_ctrl_pkg::input_sel_t    sel_d;

    // serial pins come from the host's domain: two flops each before use
    always_ff @(posedge clk_i) begin
        if (reset_any) begin
            sync1_q     <= 3'h7;
            sync2_q     <= 3'h7;
            sclk_prev_q <= 1'b1;
        end else begin
            sync1_q     <= {sclk_i, din_i, cs_n_i};
            sync2_q     <= sync1_q;
            sclk_prev_q <= sync2_q[2];
        end
    end

    // count ones taken on sclk rising edges while selected
    always_ff @(posedge clk_i) begin
        if (reset_any) begin
            ones_cnt_q     <= '0;
            serial_reset_q <= 1'b0;
        end else begin
            serial_reset_q <= 1'b0;
            if (sync2_q[0]) begin
                ones_cnt_q <= '0;
            end else if (sync2_q[2] && !sclk_prev_q) begin
                if (!sync2_q[1]) begin
                    ones_cnt_q <= '0;
                end else if (ones_cnt_q == `RESET_ONES - 6'd1) begin
                    ones_cnt_q     <= '0;
                    serial_reset_q <= 1'b1;
                end else begin
                    ones_cnt_q <= ones_cnt_q + 6'd1;
                end
            end
        end
    end

    // power-up and serial reset share one path through every register except the modulator_reset_o and conv_restart_o flops
    assign reset_any = rst_i | serial_reset_q;

    // settle window after reset, shown in status
    always_ff @(posedge clk_i) begin
        if (reset_any) begin
            rst_wait_q <= RW_W'(RESET_WAIT_CYCLES);
        end else if (rst_wait_q != '0) begin
            rst_wait_q <= rst_wait_q - RW_W'(1);
        end
    end

    // wishbone slave: ack one cycle after the request, write and read side effects on the ack edge
    assign req        = wb_cyc_i & wb_stb_i & ~ack_q;
    assign wr_en      = wb_cyc_i & wb_stb_i & wb_we_i & ack_q;
    assign rd_data_en = wb_cyc_i & wb_stb_i & ~wb_we_i & ack_q & (wb_adr_i == `ADDR_DATA);
    assign wb_ack_o   = ack_q;
    assign wb_dat_o   = rdata_q;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] dat,
                                          input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = dat[i*8 +: 8];
            end
        end
        return r;
    endfunction : merge

    assign status_word = {24'h00_0000, 1'b0, channel_q, (reference_select_q | (channel_q == `SUPPLY_CHANNEL)),
                          (rst_wait_q != '0), (state_q == adc_ctrl_pkg::ST_CALIBRATE), ready_q};

    always_comb begin
        wmerged = 32'h0000_0000;
        if (wb_adr_i == `ADDR_MODE) begin
            wmerged = merge({29'h0, mode_q}, wb_dat_i, wb_sel_i);
        end else if (wb_adr_i == `ADDR_CONFIG) begin
            wmerged = merge({21'h0, gain_q, 4'h0, reference_select_q, channel_q}, wb_dat_i, wb_sel_i);
        end else if (wb_adr_i == `ADDR_OFFSET_COEF) begin
            wmerged = merge({8'h00, offset_q[coef_idx]}, wb_dat_i, wb_sel_i);
        end else if (wb_adr_i == `ADDR_FSCALE_COEF) begin
            wmerged = merge({8'h00, fscale_q[coef_idx]}, wb_dat_i, wb_sel_i);
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_any) begin
            ack_q   <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end else begin
            ack_q <= req;
            if (req && !wb_we_i) begin
                if (wb_adr_i == `ADDR_MODE) begin
                    rdata_q <= {29'h0, mode_q};
                end else if (wb_adr_i == `ADDR_CONFIG) begin
                    rdata_q <= {21'h0, gain_q, 4'h0, reference_select_q, channel_q};
                end else if (wb_adr_i == `ADDR_STATUS) begin
                    rdata_q <= status_word;
                end else if (wb_adr_i == `ADDR_DATA) begin
                    rdata_q <= {{(32-RESULT_W){1'b0}}, data_q};
                end else if (wb_adr_i == `ADDR_OFFSET_COEF) begin
                    rdata_q <= {{(32-RESULT_W){1'b0}}, offset_q[coef_idx]};
                end else if (wb_adr_i == `ADDR_FSCALE_COEF) begin
                    rdata_q <= {{(32-RESULT_W){1'b0}}, fscale_q[coef_idx]};
                end else begin
                    rdata_q <= 32'h0000_0000;
                end
            end
        end
    end

    // configuration register
    always_ff @(posedge clk_i) begin
        if (reset_any) begin
            channel_q <= `CH_RESET;
            gain_q    <= `GAIN_RESET;
            reference_select_q  <= `REFERENCE_SELECT_RESET;
        end else if (wr_en && wb_adr_i == `ADDR_CONFIG) begin
            channel_q <= wmerged[`CFG_CH_LSB +: 3];
            reference_select_q  <= wmerged[`CFG_REFERENCE_SELECT_BIT];
            gain_q    <= wmerged[`CFG_GAIN_LSB +: 3];
        end
    end

    assign mode_write = wr_en && (wb_adr_i == `ADDR_MODE);
    assign new_mode   = wmerged[`MODE_OP_LSB +: 3];
    assign cal_start  = mode_write && new_mode[2];
    assign cal_done   = (state_q == adc_ctrl_pkg::ST_CALIBRATE) && raw_valid_i
                        && (cal_cnt_q == cal_need_q - 3'd1);

    // operating mode and calibration sequencing
    always_ff @(posedge clk_i) begin
        if (reset_any) begin
            mode_q     <= `MODE_RESET;
            state_q    <= adc_ctrl_pkg::ST_CONVERT;
            cal_cnt_q  <= '0;
            cal_need_q <= `CAL_CONV_SHORT;
        end else if (mode_write) begin
            mode_q    <= new_mode;
            cal_cnt_q <= '0;
            case (new_mode)
                `OP_CONTINUOUS, `OP_SINGLE: state_q <= adc_ctrl_pkg::ST_CONVERT;
                `OP_IDLE:                   state_q <= adc_ctrl_pkg::ST_IDLE;
                `OP_POWER_DOWN:             state_q <= adc_ctrl_pkg::ST_POWER_DOWN;
                default:                    state_q <= adc_ctrl_pkg::ST_CALIBRATE;
            endcase
            if (new_mode == `OP_INT_FULL && gain_q != `GAIN_ONE) begin
                cal_need_q <= `CAL_CONV_LONG;
            end else begin
                cal_need_q <= `CAL_CONV_SHORT;
            end
        end else begin
            case (state_q)
                adc_ctrl_pkg::ST_CONVERT: begin
                    if (raw_valid_i && mode_q == `OP_SINGLE) begin
                        mode_q  <= `OP_IDLE;
                        state_q <= adc_ctrl_pkg::ST_IDLE;
                    end
                end
                adc_ctrl_pkg::ST_CALIBRATE: begin
                    if (cal_done) begin
                        mode_q  <= `OP_IDLE;
                        state_q <= adc_ctrl_pkg::ST_IDLE;
                    end else if (raw_valid_i) begin
                        cal_cnt_q <= cal_cnt_q + 3'd1;
                    end
                end
                default: begin
                    state_q <= state_q;
                end
            endcase
        end
    end

    // channels 0..2 own a coefficient pair; any other code shares the last pair
    assign coef_idx = (channel_q < 3'h3) ? channel_q[1:0] : 2'd3;

    always_ff @(posedge clk_i) begin
        if (reset_any) begin
            for (int i = 0; i < 4; i++) begin
                offset_q[i] <= `OFFSET_RESET;
                fscale_q[i] <= `FSCALE_RESET;
            end
        end else if (cal_done) begin
            if (mode_q == `OP_INT_ZERO || mode_q == `OP_SYS_ZERO) begin
                offset_q[coef_idx] <= raw_data_i;
            end else begin
                fscale_q[coef_idx] <= raw_data_i;
            end
        end else if (wr_en && wb_adr_i == `ADDR_OFFSET_COEF) begin
            offset_q[coef_idx] <= wmerged[RESULT_W-1:0];
        end else if (wr_en && wb_adr_i == `ADDR_FSCALE_COEF) begin
            fscale_q[coef_idx] <= wmerged[RESULT_W-1:0];
        end
    end

    coef_scaler #(
        .W        (RESULT_W)
    ) u_scaler (
        .clk_i    (clk_i),
        .rst_i    (reset_any),
        .valid_i  (raw_valid_i && state_q == adc_ctrl_pkg::ST_CONVERT),
        .raw_i    (raw_data_i),
        .offset_i (offset_q[coef_idx]),
        .scale_i  (fscale_q[coef_idx]),
        .result_o (scaled),
        .valid_o  (scaled_valid)
    );

    // a result still in the scaler when a calibration starts is dropped
    assign result_load = scaled_valid && (state_q != adc_ctrl_pkg::ST_CALIBRATE);

    always_ff @(posedge clk_i) begin
        if (reset_any) begin
            data_q <= '0;
        end else if (result_load) begin
            data_q <= scaled;
        end
    end

    // ready flag: a new result or calibration end wins over a clearing read
    always_ff @(posedge clk_i) begin
        if (reset_any) begin
            ready_q <= 1'b0;
        end else if (result_load || cal_done) begin
            ready_q <= 1'b1;
        end else if (rd_data_en || cal_start) begin
            ready_q <= 1'b0;
        end
    end

    // ready pin level, low means ready
    always_ff @(posedge clk_i) begin
        if (reset_any) begin
            rdy_n_q <= 1'b1;
        end else if (cal_start) begin
            rdy_n_q <= 1'b1;
        end else if (result_load || cal_done) begin
            rdy_n_q <= 1'b0;
        end else if (rd_data_en) begin
            rdy_n_q <= 1'b1;
        end
    end

    // pin is driven only while chip select is low
    always_ff @(posedge clk_i) begin
        if (reset_any) begin
            dout_rdy_o      <= 1'b1;
            dout_rdy_oe_n_o <= 1'b1;
        end else begin
            dout_rdy_o      <= rdy_n_q;
            dout_rdy_oe_n_o <= sync2_q[0];
        end
    end

    // analog front end steering
    always_comb begin
        sel_d = adc_ctrl_pkg::SEL_CHANNEL;
        if (state_q == adc_ctrl_pkg::ST_CALIBRATE && mode_q == `OP_INT_ZERO) begin
            sel_d = adc_ctrl_pkg::SEL_ZERO;
        end else if (state_q == adc_ctrl_pkg::ST_CALIBRATE && mode_q == `OP_INT_FULL) begin
            sel_d = adc_ctrl_pkg::SEL_FULL;
        end else if (channel_q == `SUPPLY_CHANNEL) begin
            sel_d = adc_ctrl_pkg::SEL_SUPPLY;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_any) begin
            input_sel_o       <= adc_ctrl_pkg::SEL_CHANNEL;
            channel_o         <= `CH_RESET;
            gain_code_o       <= `GAIN_RESET;
            ref_internal_o    <= `REFERENCE_SELECT_RESET;
            ext_ref_connect_o <= ~`REFERENCE_SELECT_RESET;
            power_down_o      <= 1'b0;
        end else begin
            input_sel_o       <= sel_d;
            channel_o         <= channel_q;
            gain_code_o       <= gain_q;
            // supply monitor always converts against the internal reference
            ref_internal_o    <= reference_select_q | (channel_q == `SUPPLY_CHANNEL);
            ext_ref_connect_o <= ~(reference_select_q | (channel_q == `SUPPLY_CHANNEL));
            power_down_o      <= (state_q == adc_ctrl_pkg::ST_POWER_DOWN);
        end
    end

    // modulator reset on power-up and serial reset; conversion restart on every mode write
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            modulator_reset_o <= 1'b1;
            conv_restart_o    <= 1'b0;
        end else begin
            modulator_reset_o <= serial_reset_q;
            conv_restart_o    <= mode_write;
        end
    end
endmodule : adc_ctrl

// file: tb/adc_ctrl_sva.sv
// port assertions of the converter control and their bind
`timescale 1ns/1ps
`include "adc_ctrl_defines.svh"
module adc_ctrl_chk (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic        wb_we_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_ack_o,
    input wire logic        dout_rdy_o,
    input wire logic [1:0]  input_sel_o,
    input wire logic        ref_internal_o,
    input wire logic        ext_ref_connect_o,
    input wire logic        modulator_reset_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    wire logic md_wr;
    assign md_wr = wb_ack_o && wb_we_i && (wb_adr_i == `ADDR_MODE);
    property p_ack; (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o; endproperty
    a_ack: assert property (p_ack) else $error("ack not one cycle after request");
    property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack held two cycles");
    property p_ref; ext_ref_connect_o == !ref_internal_o; endproperty
    a_ref: assert property (p_ref) else $error("reference pins and internal ref both on");
    property p_sup; (input_sel_o == adc_ctrl_pkg::SEL_SUPPLY) [*2] |-> ref_internal_o; endproperty
    a_sup: assert property (p_sup) else $error("supply channel without internal ref");
    property p_busy; md_wr && wb_dat_i[2] |-> ##[1:3] dout_rdy_o; endproperty
    a_busy: assert property (p_busy) else $error("ready pin not high at cal start");
    property p_zero;
        md_wr && wb_dat_i[2:0] == `OP_INT_ZERO |-> ##[1:3] input_sel_o == adc_ctrl_pkg::SEL_ZERO;
    endproperty
    a_zero: assert property (p_zero) else $error("zero source not selected");
    property p_full;
        md_wr && wb_dat_i[2:0] == `OP_INT_FULL |-> ##[1:3] input_sel_o == adc_ctrl_pkg::SEL_FULL;
    endproperty
    a_full: assert property (p_full) else $error("full-scale source not selected");
    property p_rst; disable iff (1'b0) rst_i |=> modulator_reset_o; endproperty
    a_rst: assert property (p_rst) else $error("modulator not reset");
    c_sys_full: cover property (md_wr && wb_dat_i[2:0] == `OP_SYS_FULL);
    c_done: cover property ($fell(dout_rdy_o));
    c_serial_reset: cover property (modulator_reset_o && !rst_i);
endmodule : adc_ctrl_chk
bind adc_ctrl adc_ctrl_chk u_chk (.*);

// file: tb/host_serial_model.sv
// host side of the three-wire serial link
`timescale 1ns/1ps
module host_serial_model (
    input  wire logic clk_i,
    output logic      sclk_o,
    output logic      din_o,
    output logic      cs_n_o
);
    initial begin
        sclk_o = 1'b0;
        din_o  = 1'b0;
        cs_n_o = 1'b1;
    end
    task automatic select(input logic n);
        @(posedge clk_i);
        cs_n_o <= n;
    endtask : select
    // n bits of value b, 400 ns each; clock stands low outside frames
    task automatic send(input int n, input logic b);
        for (int i = 0; i < n; i++) begin
            @(posedge clk_i);
            din_o <= b;
            repeat (3) @(posedge clk_i);
            sclk_o <= 1'b1;
            repeat (4) @(posedge clk_i);
            sclk_o <= 1'b0;
        end
        din_o <= ~b;
    endtask : send
endmodule : host_serial_model

// file: tb/tb_top.sv
// self-checking bench of the converter control
`timescale 1ns/1ps
`include "adc_ctrl_defines.svh"
module tb_top;
    localparam int unsigned WAIT_C = 20;
    logic clk_i = 1'b0, rst_i = 1'b1, wb_we_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
    logic [7:0]  wb_adr_i = 8'h00;
    logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o, q;
    logic [3:0]  wb_sel_i = 4'hF;
    logic [23:0] raw_data_i = 24'h00_0000;
    logic [1:0]  input_sel_o;
    logic [2:0]  channel_o, gain_code_o;
    logic raw_valid_i = 1'b0, wb_ack_o, sclk_i, din_i, cs_n_i, dout_rdy_o, dout_rdy_oe_n_o;
    logic ref_internal_o, ext_ref_connect_o, modulator_reset_o, conv_restart_o, power_down_o;
    logic mr_seen = 1'b0, rst_d = 1'b1;
    int   bad_count = 0, check_count = 0;
    always #25 clk_i = ~clk_i;
    // delayed reset keeps the pulse that follows power-up reset out of the serial reset test
    always @(posedge clk_i) begin
        rst_d <= rst_i;
        if (modulator_reset_o && !rst_d) mr_seen <= 1'b1;
    end
    adc_ctrl #(.RESET_WAIT_CYCLES(WAIT_C)) DUT (.*);
    host_serial_model u_host (.clk_i(clk_i), .sclk_o(sclk_i), .din_o(din_i), .cs_n_o(cs_n_i));
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", s, e, g);
        end
    endtask : chk
    task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        if (n >= 50) begin
            chk("bus ack", 1'b1, 1'b0);
            results();
        end
    endtask : wb
    task automatic pulse(input logic [23:0] v);
        @(posedge clk_i);
        raw_valid_i <= 1'b1;
        raw_data_i  <= v;
        @(posedge clk_i);
        raw_valid_i <= 1'b0;
        repeat (6) @(posedge clk_i);
    endtask : pulse
    task automatic t_reset();
        logic [7:0]  a [4] = '{`ADDR_MODE, `ADDR_CONFIG, `ADDR_OFFSET_COEF, `ADDR_FSCALE_COEF};
        logic [31:0] e [4] = '{32'h0, 32'h0, 32'h0, 32'h0080_0000};
        for (int i = 0; i < 4; i++) begin
            wb(a[i], 1'b0, 32'h0);
            chk("reset value", e[i], q);
        end
        wb(8'hFC, 1'b0, 32'h0);
        chk("unmapped", 32'h0, q);
        $display("test reset done");
    endtask : t_reset
    task automatic t_conv();
        wb(`ADDR_OFFSET_COEF, 1'b1, 32'h0000_0010);
        wb(`ADDR_FSCALE_COEF, 1'b1, 32'h0040_0000);
        wb(`ADDR_MODE, 1'b1, 32'h0);
        pulse(24'h00_1000);
        chk("conv pin", 1'b0, dout_rdy_o);
        wb(`ADDR_DATA, 1'b0, 32'h0);
        chk("scaled data", 32'h0000_07F8, q);
        $display("test conversion done");
    endtask : t_conv
    task automatic t_cal(input logic [2:0] md, input logic [2:0] g, input int n,
                         input logic [7:0] ca);
        logic [23:0] v = 24'h12_3450 + 24'(md) + 24'(g);
        // ready is left set by a previous calibration, so the start itself must clear flag and pin
        wb(`ADDR_CONFIG, 1'b1, {21'h0, g, 8'h01});
        u_host.select(1'b0);
        wb(`ADDR_MODE, 1'b1, {29'h0, md});
        repeat (4) @(posedge clk_i);
        chk("pin busy", 1'b1, dout_rdy_o);
        chk("pin enable", 1'b0, dout_rdy_oe_n_o);
        for (int i = 1; i < n; i++) pulse(24'h00_0100);
        wb(`ADDR_STATUS, 1'b0, 32'h0);
        chk("calibrating", 32'h2, q[1:0]);
        pulse(v);
        chk("pin ready", 1'b0, dout_rdy_o);
        wb(`ADDR_STATUS, 1'b0, 32'h0);
        chk("ready flag", 1'b1, q[0]);
        wb(`ADDR_MODE, 1'b0, 32'h0);
        chk("idle", `OP_IDLE, q);
        wb(ca, 1'b0, 32'h0);
        chk("coefficient", {8'h00, v}, q);
        $display("test calibration %0d done", md);
    endtask : t_cal
    task automatic t_ref();
        wb(`ADDR_CONFIG, 1'b1, 32'h0000_0008);
        repeat (2) @(posedge clk_i);
        chk("internal ref", 2'b10, {ref_internal_o, ext_ref_connect_o});
        wb(`ADDR_MODE, 1'b1, 32'h0);
        wb(`ADDR_CONFIG, 1'b1, 32'h0000_0007);
        repeat (3) @(posedge clk_i);
        chk("supply input", adc_ctrl_pkg::SEL_SUPPLY, input_sel_o);
        chk("supply ref", 1'b1, ref_internal_o);
        wb(`ADDR_CONFIG, 1'b1, 32'h0000_0001);
        repeat (2) @(posedge clk_i);
        chk("external ref", 2'b01, {ref_internal_o, ext_ref_connect_o});
        $display("test reference done");
    endtask : t_ref
    task automatic t_modes();
        wb(`ADDR_MODE, 1'b1, {29'h0, `OP_POWER_DOWN});
        @(posedge clk_i);
        chk("restart", 1'b1, conv_restart_o);
        @(posedge clk_i);
        chk("power down", 1'b1, power_down_o);
        chk("channel gain", 6'h08, {channel_o, gain_code_o});
        wb(`ADDR_MODE, 1'b1, {29'h0, `OP_SINGLE});
        pulse(24'h00_0200);
        wb(`ADDR_MODE, 1'b0, 32'h0);
        chk("single to idle", `OP_IDLE, q);
        $display("test modes done");
    endtask : t_modes
    task automatic t_serial();
        wb(`ADDR_CONFIG, 1'b1, 32'h0000_0305);
        u_host.select(1'b0);
        u_host.send(31, 1'b1);
        u_host.send(1, 1'b0);
        u_host.send(31, 1'b1);
        repeat (8) @(posedge clk_i);
        chk("no early reset", 1'b0, mr_seen);
        u_host.send(1, 1'b1);
        u_host.select(1'b1);
        repeat (WAIT_C + 8) @(posedge clk_i);
        chk("modulator reset", 1'b1, mr_seen);
        wb(`ADDR_CONFIG, 1'b0, 32'h0);
        chk("config reset", 32'h0, q);
        wb(`ADDR_STATUS, 1'b0, 32'h0);
        chk("reset wait", 32'h0, q[2]);
        $display("test serial reset done");
    endtask : t_serial
    task automatic results();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : results
    initial begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (WAIT_C + 4) @(posedge clk_i);
        t_reset();
        t_conv();
        t_cal(`OP_INT_ZERO, 3'h0, 2, `ADDR_OFFSET_COEF);
        t_cal(`OP_INT_FULL, 3'h0, 2, `ADDR_FSCALE_COEF);
        t_cal(`OP_INT_FULL, 3'h3, 4, `ADDR_FSCALE_COEF);
        t_cal(`OP_SYS_ZERO, 3'h7, 2, `ADDR_OFFSET_COEF);
        t_cal(`OP_SYS_FULL, 3'h7, 2, `ADDR_FSCALE_COEF);
        u_host.select(1'b1);
        wb(`ADDR_CONFIG, 1'b1, 32'h0000_0002);
        wb(`ADDR_FSCALE_COEF, 1'b0, 32'h0);
        chk("other channel", 32'h0080_0000, q);
        t_ref();
        t_modes();
        t_serial();
        results();
    end
    initial begin
        repeat (20000) @(posedge clk_i);
        bad_count++;
        results();
    end
endmodule : tb_top
